// [ddr4_init_pkg.sv]
// Constants, types and command encoders for the DDR4 init and mode register controller
package ddr4_init_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned T_RESET_NS    = 100;
   localparam int unsigned T_CKE_LOW_NS  = 10;
   localparam int unsigned T_CKE_WAIT_US = 500;
   localparam int unsigned T_IDLE_MS     = 960;
   localparam int unsigned CYC_PER_US    = 1000000 / CLK_PERIOD_PS;
   localparam int unsigned T_RST_CYC     = (T_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned T_CKE_LOW_CYC = (T_CKE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned T_CKE_WAIT_CYC = T_CKE_WAIT_US * CYC_PER_US;
   localparam int unsigned T_IDLE_CYC    = T_IDLE_MS * 1000 * CYC_PER_US;
   // Keep-alive fires this many cycles before the idle limit
   localparam int unsigned KEEP_MARGIN   = 1024;
   // Command spacings in controller cycles
   localparam int unsigned T_XPR_CYC     = 64;
   localparam int unsigned T_MRD_CYC     = 8;
   localparam int unsigned T_MOD_CYC     = 24;
   localparam int unsigned T_FUNC_CYC    = 64;
   localparam int unsigned T_ZQ_CYC      = 1024;

   // ------------------------------------------------------------
   // Mode register layout
   // ------------------------------------------------------------
   localparam int unsigned MR_COUNT    = 7;
   localparam int unsigned MR_BITS     = 18;
   localparam logic [2:0]  MR_SEL_LAST = 3'h0;
   localparam logic [2:0]  MR_SEL_BAD  = 3'h7;
   localparam logic [2:0]  IDX_LAST    = 3'h6;
   localparam logic [2:0]  IDX_REINIT  = 3'h5;
   localparam int unsigned ZQ_LONG_BIT = 10;

   typedef logic [MR_BITS-1:0] mr_val_t;

   typedef struct packed {
      logic          act_n;
      logic          ras_n;
      logic          cas_n;
      logic          we_n;
      logic [1:0]    bg;
      logic [1:0]    ba;
      logic [17:0]   addr;
   } ddr_cmd_t;

   typedef enum logic [2:0] {
      ST_RST_HOLD, ST_CKE_WAIT, ST_XPR, ST_MRS, ST_MRS_GAP, ST_ZQ, ST_ZQ_WAIT, ST_READY
   } init_st_t;

   localparam ddr_cmd_t DES_CMD = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 18'h0};
   localparam ddr_cmd_t REF_CMD = '{1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 2'h0, 18'h0};
   localparam ddr_cmd_t ZQL_CMD = '{1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0, 18'h00400};

   // Select sits on BG0/BA1/BA0, BG1 stays zero
   function automatic ddr_cmd_t mrs_cmd(input logic [2:0] sel, input mr_val_t val);
      return '{1'b1, 1'b0, 1'b0, 1'b0, {1'b0, sel[2]}, sel[1:0], val};
   endfunction

   // Init load order MR3 MR6 MR5 MR4 MR2 MR1 MR0
   function automatic logic [2:0] mr_order(input logic [2:0] idx);
      unique case (idx)
         3'h0:    return 3'h3;
         3'h1:    return 3'h6;
         3'h2:    return 3'h5;
         3'h3:    return 3'h4;
         3'h4:    return 3'h2;
         3'h5:    return 3'h1;
         default: return 3'h0;
      endcase
   endfunction

endpackage

// [ddr4_init_ctrl.sv]
// Host-side DDR4 reset, initialization and mode register controller
// Summary of operation
// - Keep-alive refresh before 960 ms idle, sent only while ALL_IDLE is high
// - Debug 60 minute idle stretch not used
// - Supply change reruns DLL reset, calibration
// - Deselect between init MRS and ZQCL
// - Write every defined mode register at init
// - DLL enable MR1 before DLL reset MR0
// - Test input held low throughout
// - Reset low 100 ns, CKE low first
// - Warm reset reuses power-on steps
// - Fully load registers after every reset
// - Every MRS carries full field value
// - At least tMRD between MRS commands
// - Feature-changing MRS waits function time
// - tMOD before non-MRS command
// - Special MRS use longer function timing
// - Runtime MRS only while device idle
// - ODT low around MRS with RTT_NOM
// - ODT free when RTT_NOM off
// - Wait 500 us after reset before CKE
// - ZQCL after last load, then wait
// - Three-bit select, code 111 unused
// - RAS, CAS, WE low for MRS
`timescale 1ns/10ps
`default_nettype none

module ddr4_init_ctrl
   import ddr4_init_pkg::*;
#(
   parameter int unsigned CKE_WAIT_CYC = T_CKE_WAIT_CYC,
   parameter int unsigned IDLE_CYC     = T_IDLE_CYC
)(
   // Clock and reset
   input  wire logic                     MCLK,
   input  wire logic                     RESET,
   // Init control
   input  wire logic                     START,
   input  wire logic                     REINIT,
   input  wire mr_val_t [MR_COUNT-1:0]   MR_INIT,
   input  wire logic [MR_COUNT-1:0]      INIT_SLOW,
   output var  logic                     READY,
   // Runtime mode register write
   input  wire logic                     MRS_VALID,
   input  wire logic [2:0]               MRS_SEL,
   input  wire mr_val_t                  MRS_DATA,
   input  wire logic                     MRS_SLOW,
   output logic                          MRS_READY,
   // Other commands
   input  wire logic                     CMD_VALID,
   input  wire ddr_cmd_t                 CMD,
   output logic                          CMD_READY,
   // Device state seen by the user
   input  wire logic                     ALL_IDLE,
   input  wire logic                     RTT_NOM_ON,
   input  wire logic                     ODT_REQ,
   // Device pins
   output var  logic                     RESET_N,
   output var  logic                     CKE,
   output var  logic                     CS_N,
   output var  ddr_cmd_t                 DDR_CMD,
   output var  logic                     ODT,
   output var  logic                     TEN
);

   // ------------------------------------------------------------
   // Issue decisions
   // ------------------------------------------------------------
   init_st_t    st;
   logic [31:0] wait_cnt;
   logic [31:0] gap;
   logic [2:0]  mr_idx;
   logic [7:0]  mrd_cnt;
   logic [7:0]  mod_cnt;
   logic [31:0] idle_cnt;
   logic        keep_due;
   logic        ref_fire;
   logic        reinit_fire;
   logic        user_mrs;
   logic        init_mrs;
   logic        mrs_slow;
   logic [2:0]  init_sel;

   assign init_sel = mr_order(mr_idx);
   assign init_mrs = (st == ST_MRS);
   assign mrs_slow = init_mrs ? INIT_SLOW[init_sel] : MRS_SLOW;

   assign keep_due = (idle_cnt >= IDLE_CYC - KEEP_MARGIN) && ALL_IDLE;
   assign ref_fire = (st == ST_READY) && !START && !REINIT && keep_due && (mod_cnt == 8'h0);
   assign reinit_fire = (st == ST_READY) && !START && REINIT && ALL_IDLE && (mrd_cnt == 8'h0)
                        && !(RTT_NOM_ON && ODT);
   assign MRS_READY = (st == ST_READY) && !START && !REINIT && !keep_due && ALL_IDLE
                      && (mrd_cnt == 8'h0) && !(RTT_NOM_ON && ODT) && (MRS_SEL != MR_SEL_BAD);
   assign user_mrs  = MRS_VALID && MRS_READY;
   assign CMD_READY = (st == ST_READY) && !START && !REINIT && !keep_due && !user_mrs
                      && (mod_cnt == 8'h0);

   // ------------------------------------------------------------
   // Sequencer and command pins
   // ------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         st       <= ST_RST_HOLD;
         wait_cnt <= 32'h0;
         gap      <= 32'h0;
         mr_idx   <= 3'h0;
         RESET_N  <= 1'b0;
         CKE      <= 1'b0;
         CS_N     <= 1'b1;
         DDR_CMD  <= DES_CMD;
         READY    <= 1'b0;
      end else begin
         CS_N     <= 1'b1;
         DDR_CMD  <= DES_CMD;
         wait_cnt <= wait_cnt + 32'h1;
         unique case (st)
            ST_RST_HOLD: begin
               RESET_N <= 1'b0;
               CKE     <= 1'b0;
               if (wait_cnt >= 32'(T_RST_CYC - 1) && wait_cnt >= 32'(T_CKE_LOW_CYC)) begin
                  RESET_N  <= 1'b1;
                  wait_cnt <= 32'h0;
                  st       <= ST_CKE_WAIT;
               end
            end
            ST_CKE_WAIT: begin
               if (wait_cnt >= CKE_WAIT_CYC - 1) begin
                  CKE      <= 1'b1;
                  wait_cnt <= 32'h0;
                  st       <= ST_XPR;
               end
            end
            ST_XPR: begin
               if (wait_cnt >= 32'(T_XPR_CYC - 1)) begin
                  mr_idx <= 3'h0;
                  st     <= ST_MRS;
               end
            end
            ST_MRS: begin
               CS_N     <= 1'b0;
               DDR_CMD  <= mrs_cmd(init_sel, MR_INIT[init_sel]);
               wait_cnt <= 32'h0;
               if (mrs_slow) begin
                  gap <= 32'(T_FUNC_CYC);
               end else if (mr_idx == IDX_LAST) begin
                  gap <= 32'(T_MOD_CYC);
               end else begin
                  gap <= 32'(T_MRD_CYC);
               end
               st <= ST_MRS_GAP;
            end
            ST_MRS_GAP: begin
               if (wait_cnt >= gap - 32'h1) begin
                  if (mr_idx == IDX_LAST) begin
                     st <= ST_ZQ;
                  end else begin
                     mr_idx <= mr_idx + 3'h1;
                     st     <= ST_MRS;
                  end
               end
            end
            ST_ZQ: begin
               CS_N     <= 1'b0;
               DDR_CMD  <= ZQL_CMD;
               wait_cnt <= 32'h0;
               st       <= ST_ZQ_WAIT;
            end
            ST_ZQ_WAIT: begin
               if (wait_cnt >= 32'(T_ZQ_CYC - 1)) begin
                  READY <= 1'b1;
                  st    <= ST_READY;
               end
            end
            ST_READY: begin
               if (START) begin
                  READY    <= 1'b0;
                  RESET_N  <= 1'b0;
                  CKE      <= 1'b0;
                  wait_cnt <= 32'h0;
                  st       <= ST_RST_HOLD;
               end else if (reinit_fire) begin
                  READY  <= 1'b0;
                  mr_idx <= IDX_REINIT;
                  st     <= ST_MRS;
               end else if (ref_fire) begin
                  CS_N    <= 1'b0;
                  DDR_CMD <= REF_CMD;
               end else if (user_mrs) begin
                  CS_N    <= 1'b0;
                  DDR_CMD <= mrs_cmd(MRS_SEL, MRS_DATA);
               end else if (CMD_VALID && CMD_READY) begin
                  CS_N    <= 1'b0;
                  DDR_CMD <= CMD;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // MRS spacing counters
   // ------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         mrd_cnt <= 8'h0;
         mod_cnt <= 8'h0;
      end else if (init_mrs || user_mrs) begin
         mrd_cnt <= mrs_slow ? 8'(T_FUNC_CYC) : 8'(T_MRD_CYC);
         mod_cnt <= mrs_slow ? 8'(T_FUNC_CYC) : 8'(T_MOD_CYC);
      end else begin
         mrd_cnt <= (mrd_cnt != 8'h0) ? mrd_cnt - 8'h1 : 8'h0;
         mod_cnt <= (mod_cnt != 8'h0) ? mod_cnt - 8'h1 : 8'h0;
      end
   end

   // ------------------------------------------------------------
   // Idle keep-alive counter
   // ------------------------------------------------------------
   // restart on activity
   always_ff @(posedge MCLK) begin
      if (RESET || st != ST_READY || !CS_N || ref_fire) begin
         idle_cnt <= 32'h0;
      end else begin
         idle_cnt <= idle_cnt + 32'h1;
      end
   end

   // ------------------------------------------------------------
   // ODT and test pin
   // ------------------------------------------------------------
   // Held low through init so it stays static until calibration ends
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ODT <= 1'b0;
         TEN <= 1'b0;
      end else begin
         TEN <= 1'b0;
         ODT <= (st == ST_READY) && ODT_REQ
                && !(RTT_NOM_ON && (MRS_VALID || REINIT || mod_cnt != 8'h0));
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic        is_mrs;
   logic        is_cmd;
   logic [7:0]  since_mrs;
   logic [7:0]  rst_low;
   logic [31:0] since_rel;
   logic [2:0]  last_sel;

   assign is_mrs = !CS_N && DDR_CMD.act_n && !DDR_CMD.ras_n && !DDR_CMD.cas_n && !DDR_CMD.we_n;
   assign is_cmd = !CS_N && !is_mrs;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         since_mrs <= 8'hff;
         rst_low   <= 8'h0;
         since_rel <= 32'h0;
         last_sel  <= 3'h7;
      end else begin
         since_mrs <= is_mrs ? 8'h1 : ((since_mrs == 8'hff) ? 8'hff : since_mrs + 8'h1);
         rst_low   <= RESET_N ? 8'h0 : ((rst_low == 8'hff) ? 8'hff : rst_low + 8'h1);
         since_rel <= !RESET_N ? 32'h0 : since_rel + 32'h1;
         if (is_mrs) begin
            last_sel <= {DDR_CMD.bg[0], DDR_CMD.ba};
         end
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   property p_ten_low;
      TEN == 1'b0;
   endproperty
   a_ten_low: assert property (p_ten_low) else $error("Test pin not low");

   property p_rst_hold;
      $rose(RESET_N) |-> (rst_low >= T_RST_CYC) && !CKE && !$past(CKE, 2);
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("Reset released early");

   property p_cke_wait;
      $rose(CKE) |-> since_rel >= CKE_WAIT_CYC;
   endproperty
   a_cke_wait: assert property (p_cke_wait) else $error("CKE raised too soon");

   property p_mrd;
      is_mrs |-> since_mrs >= T_MRD_CYC;
   endproperty
   a_mrd: assert property (p_mrd) else $error("MRS spacing short");

   property p_mod;
      is_cmd |-> since_mrs >= T_MOD_CYC;
   endproperty
   a_mod: assert property (p_mod) else $error("Command inside tMOD");

   property p_odt;
      RTT_NOM_ON && since_mrs <= T_MOD_CYC |-> !ODT;
   endproperty
   a_odt: assert property (p_odt) else $error("ODT high near MRS");

   property p_des_gap;
      is_mrs && !READY |=> CS_N [*2];
   endproperty
   a_des_gap: assert property (p_des_gap) else $error("No deselect after MRS");

   property p_mr_sel;
      is_mrs |-> {DDR_CMD.bg[0], DDR_CMD.ba} != MR_SEL_BAD && !DDR_CMD.bg[1];
   endproperty
   a_mr_sel: assert property (p_mr_sel) else $error("Illegal register select");

   property p_zq_last;
      !CS_N && DDR_CMD == ZQL_CMD && !READY |-> last_sel == MR_SEL_LAST;
   endproperty
   a_zq_last: assert property (p_zq_last) else $error("ZQCL not after MR0");

   property p_idle;
      idle_cnt < IDLE_CYC;
   endproperty
   a_idle: assert property (p_idle) else $error("Idle limit passed");

   property p_init_done;
      $rose(READY);
   endproperty
   c_init_done: cover property (p_init_done);

   property p_user_mrs;
      user_mrs ##1 is_mrs;
   endproperty
   c_user_mrs: cover property (p_user_mrs);

   property p_keep_ref;
      ref_fire;
   endproperty
   c_keep_ref: cover property (p_keep_ref);

   property p_warm;
      READY && START ##1 !RESET_N;
   endproperty
   c_warm: cover property (p_warm);

endmodule

`default_nettype wire

// [ddr4_dev_model.sv]
// Behavioural device model that watches the controller's pins
`timescale 1ns/10ps
`default_nettype none

module ddr4_dev_model
   import ddr4_init_pkg::*;
(
   // Clock
   input  wire logic     MCLK,
   // Device pins
   input  wire logic     RESET_N,
   input  wire logic     CKE,
   input  wire logic     CS_N,
   input  wire ddr_cmd_t DDR_CMD,
   input  wire logic     ODT,
   input  wire logic     TEN
);
   // ------------------------------------------------------------
   // State and watch counters
   // ------------------------------------------------------------
   mr_val_t     mr [MR_COUNT];
   ddr_cmd_t    log_cmd [$];
   int unsigned log_cyc [$];
   int unsigned cyc = 0, rst_run = 0, rst_len = 0, wait_run = 0, cke_wait = 0;
   int unsigned cke_early = 0, ref_cnt = 0, non_des = 0, ten_bad = 0, odt_bad = 0;
   int unsigned bad_sel = 0, last_mrs = 0;
   logic        rn_q = 1'b0, cke_q = 1'b0, mrs_seen = 1'b0, is_mrs;
   logic [2:0]  sel;

   // ------------------------------------------------------------
   // Pin decode
   // ------------------------------------------------------------
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      rn_q <= RESET_N;
      cke_q <= CKE;
      is_mrs = CS_N === 1'b0 && !DDR_CMD.ras_n && !DDR_CMD.cas_n && !DDR_CMD.we_n;
      if (cyc != 0 && TEN !== 1'b0) ten_bad <= ten_bad + 1;
      if (RESET_N !== 1'b1) begin
         rst_run <= rst_run + 1;
         wait_run <= 0;
         if (cyc != 0 && CKE !== 1'b0) cke_early <= cke_early + 1;
         // counters and registers lost, refresh count kept
         mrs_seen <= 1'b0;
         for (int i = 0; i < MR_COUNT; i++) mr[i] <= '1;
      end else begin
         rst_run <= 0;
         if (!rn_q) rst_len <= rst_run;
         if (!CKE) wait_run <= wait_run + 1;
         if (CKE && !cke_q) cke_wait <= wait_run;
      end
      if (CS_N === 1'b1 && DDR_CMD !== DES_CMD) non_des <= non_des + 1;
      // Termination must stay off from the write until tMOD has run out
      if ((is_mrs || (mrs_seen && cyc - last_mrs <= T_MOD_CYC)) && ODT !== 1'b0)
         odt_bad <= odt_bad + 1;
      if (RESET_N === 1'b1 && CKE === 1'b1 && CS_N === 1'b0) begin
         log_cmd.push_back(DDR_CMD);
         log_cyc.push_back(cyc);
         // select decode, whole value, array untouched
         if (is_mrs) begin
            sel = {DDR_CMD.bg[0], DDR_CMD.ba};
            if (sel == 3'h7) bad_sel <= bad_sel + 1;
            else mr[sel] <= DDR_CMD.addr;
            last_mrs <= cyc;
            mrs_seen <= 1'b1;
         end
         if (DDR_CMD.act_n && !DDR_CMD.ras_n && !DDR_CMD.cas_n && DDR_CMD.we_n)
            ref_cnt <= ref_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// [tb_ddr4_init_and_mode_register_programming.sv]
// Self-checking testbench for the DDR4 init and mode register controller
`timescale 1ns/10ps
`default_nettype none

module tb_ddr4_init_and_mode_register_programming;
   import ddr4_init_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   // Short counts keep the run brief
   localparam int unsigned CKW = 50;
   localparam int unsigned IDL = 3000;
   logic mclk, reset, start, reinit, mrs_valid, mrs_slow, cmd_valid, all_idle, rtt_nom_on;
   logic odt_req, ready, mrs_ready, cmd_ready, reset_n, cke, cs_n, odt, ten;
   mr_val_t [MR_COUNT-1:0] mr_init;
   logic [MR_COUNT-1:0]    init_slow;
   logic [2:0]             mrs_sel;
   mr_val_t                mrs_data;
   ddr_cmd_t               cmd, ddr_cmd, c;
   int unsigned            fail_count = 0, samples_checked = 0, k, last;
   int unsigned            ord [7] = '{3, 6, 5, 4, 2, 1, 0};

   ddr4_init_ctrl #(.CKE_WAIT_CYC(CKW), .IDLE_CYC(IDL)) dut_u (
      .MCLK(mclk), .RESET(reset), .START(start), .REINIT(reinit), .MR_INIT(mr_init),
      .INIT_SLOW(init_slow), .READY(ready), .MRS_VALID(mrs_valid), .MRS_SEL(mrs_sel),
      .MRS_DATA(mrs_data), .MRS_SLOW(mrs_slow), .MRS_READY(mrs_ready),
      .CMD_VALID(cmd_valid), .CMD(cmd), .CMD_READY(cmd_ready), .ALL_IDLE(all_idle),
      .RTT_NOM_ON(rtt_nom_on), .ODT_REQ(odt_req), .RESET_N(reset_n), .CKE(cke),
      .CS_N(cs_n), .DDR_CMD(ddr_cmd), .ODT(odt), .TEN(ten));

   ddr4_dev_model dev_u (.MCLK(mclk), .RESET_N(reset_n), .CKE(cke), .CS_N(cs_n),
      .DDR_CMD(ddr_cmd), .ODT(odt), .TEN(ten));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic clear_log;
      dev_u.log_cmd.delete();
      dev_u.log_cyc.delete();
   endtask

   function automatic int unsigned gap(input int unsigned i);
      return dev_u.log_cyc[i + 1] - dev_u.log_cyc[i];
   endfunction

   // Holds the request until the ready seen at a falling edge is taken
   task automatic hs(input bit m);
      int unsigned i;
      @(negedge mclk);
      if (m) mrs_valid = 1'b1;
      else cmd_valid = 1'b1;
      for (i = 0; i < 300 && (m ? mrs_ready : cmd_ready) !== 1'b1; i++) @(negedge mclk);
      @(negedge mclk);
      mrs_valid = 1'b0;
      cmd_valid = 1'b0;
   endtask

   task automatic wait_ready;
      int unsigned i;
      for (i = 0; i < 4000 && ready !== 1'b1; i++) @(negedge mclk);
      check("ready", ready, 1'b1);
   endtask

   // Checks the last n register loads of the init order, then ZQCL
   task automatic chk_seq(input int unsigned n);
      int unsigned s, need;
      check("cmd_count", dev_u.log_cmd.size(), n + 1);
      for (int unsigned j = 0; j < n; j++) begin
         c = dev_u.log_cmd[j];
         s = ord[7 - n + j];
         need = init_slow[s] ? T_FUNC_CYC : (j == n - 1 ? T_MOD_CYC : T_MRD_CYC);
         check("mr_sel", {c.bg[0], c.ba}, s);
         check("mrs_pins", {c.ras_n, c.cas_n, c.we_n, c.bg[1]}, 4'h0);
         check("mr_value", c.addr, mr_init[s]);
         check("mrs_gap", gap(j) >= need + 1, 1'b1);
      end
      c = dev_u.log_cmd[n];
      check("zq_pins", {c.ras_n, c.cas_n, c.we_n, c.addr[10]}, 4'hd);
      check("zq_wait", dev_u.cyc - dev_u.log_cyc[n] >= T_ZQ_CYC, 1'b1);
      check("deselect", dev_u.non_des, 0);
      check("ten_low", dev_u.ten_bad, 0);
      check("bad_sel", dev_u.bad_sel, 0);
   endtask

   task automatic chk_reset;
      wait_ready();
      check("rst_len", dev_u.rst_len >= T_RST_CYC, 1'b1);
      check("cke_early", dev_u.cke_early, 0);
      check("cke_wait", dev_u.cke_wait >= CKW, 1'b1);
      chk_seq(7);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_init;
      chk_reset();
      $display("Test init done");
   endtask

   task automatic t_mrs;
      clear_log();
      all_idle = 1'b0;
      mrs_valid = 1'b1;
      repeat (4) @(negedge mclk);
      check("busy_refuse", mrs_ready, 1'b0);
      mrs_valid = 1'b0;
      all_idle = 1'b1;
      rtt_nom_on = 1'b1;
      mrs_sel = 3'h7;
      @(negedge mclk);
      check("bad_sel_refuse", mrs_ready, 1'b0);
      mrs_sel = 3'h2;
      mrs_data = 18'h0c3a5;
      hs(1'b1);
      mrs_slow = 1'b0;
      mrs_sel = 3'h6;
      mrs_data = 18'h01b7e;
      hs(1'b1);
      mrs_sel = 3'h4;
      hs(1'b1);
      odt_req = 1'b1;
      hs(1'b0);
      repeat (30) @(negedge mclk);
      check("rt_count", dev_u.log_cmd.size(), 4);
      check("slow_gap", gap(0) >= T_FUNC_CYC + 1, 1'b1);
      check("mrd_gap", gap(1) >= T_MRD_CYC + 1, 1'b1);
      check("mod_gap", gap(2) >= T_MOD_CYC + 1, 1'b1);
      check("mr2", dev_u.mr[2], 18'h0c3a5);
      check("mr4", dev_u.mr[4], 18'h01b7e);
      check("odt_low", dev_u.odt_bad, 0);
      check("cmd", dev_u.log_cmd[3], cmd);
      check("odt_on", odt, 1'b1);
      odt_req = 1'b0;
      rtt_nom_on = 1'b0;
      $display("Test runtime write done");
   endtask

   task automatic t_keep;
      last = dev_u.log_cyc[$];
      clear_log();
      repeat (2 * IDL) @(negedge mclk);
      check("ref_seen", dev_u.log_cmd.size() >= 1, 1'b1);
      for (k = 0; k < dev_u.log_cmd.size(); k++) begin
         c = dev_u.log_cmd[k];
         check("ref_pins", {c.act_n, c.ras_n, c.cas_n, c.we_n}, 4'h9);
         check("ref_gap", dev_u.log_cyc[k] - last <= IDL, 1'b1);
         last = dev_u.log_cyc[k];
      end
      check("idle_tail", dev_u.cyc - last <= IDL, 1'b1);
      $display("Test keep-alive done");
   endtask

   task automatic t_warm;
      last = dev_u.ref_cnt;
      clear_log();
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      repeat (3) @(negedge mclk);
      check("warm_busy", {ready, reset_n, cke}, 3'h0);
      chk_reset();
      check("ref_kept", dev_u.ref_cnt, last);
      $display("Test warm reset done");
   endtask

   task automatic t_reinit;
      clear_log();
      reinit = 1'b1;
      @(negedge mclk);
      reinit = 1'b0;
      repeat (2) @(negedge mclk);
      check("reinit_busy", ready, 1'b0);
      wait_ready();
      chk_seq(2);
      $display("Test reinit done");
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      {reset, start, reinit, mrs_valid, cmd_valid, all_idle, rtt_nom_on, odt_req} = 8'h80;
      mrs_slow = 1'b1;
      mrs_sel = 3'h2;
      mrs_data = 18'h0;
      init_slow = 7'h08;
      cmd = '{1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 18'h00400};
      for (int i = 0; i < MR_COUNT; i++) mr_init[i] = 18'h0a5a0 + 18'(i);
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      t_init();
      t_mrs();
      t_keep();
      t_warm();
      t_reinit();
      finish_test();
   end

   // Whole run needs about 10000 cycles
   initial begin
      repeat (40000) @(posedge mclk);
      fail_count++;
      $display("MISMATCH watchdog expected done seen timeout");
      finish_test();
   end
endmodule
`default_nettype wire
